// ### sod_decoder.v
// Function
// - Primary byte 95 is a prefix joined with next byte into variant code.
// - Primary 00-3F decode as value fetch; low bits form address operand.
// - Primary 40-7F decode as reference fetch.
// - FE is no operation in every mode.
// - FF is invalid operator in every mode.
// - DF is conditional halt in every mode.
// - Edit mode D0-DE select edit micro-operations; DE ends editing.
// - Primary E7 enters vector mode single pass, EF multiple passes.
// - Vector mode E6 exits back to primary mode.
// - Vector E0-E5 load A/B/C, F0-F5 store; odd codes increment.
// - Primary 80-87 select the eight arithmetic operations in order.
// - Primary 88-8D select the six relational tests in order.
// - 8E selects sign inversion, 8F extended multiply.
// - Primary 90-94 select the five bitwise logic operations.
// - 96-9F bit and field operations; odd code is dynamic form.
// - A0-A2 branches false/true/always; A8-AA dynamic forms.
// - B0/B1 push zero/one; B2, B3, BE push 8, 16, 48-bit literals.
// - Variant 9544 idle; 9546 enables, 9547 disables external interrupts.
// - Primary F0-F5 destructive character compares; F8-FD updating forms.
// - Variant 95F0-95F5 destructive scan relations; 95F8-95FD updating.
// - Variant 95D0-95D5, 95D8-95DD unpack, transfer and scan while.
//
// Purpose: Operator decoder for a stack-oriented processor
// Assumes: One operator byte offered per cycle with a valid strobe
// Notes: Result registered one cycle after the byte is taken
`timescale 1ns/1ps
`default_nettype none
`include "sod_consts.vh"

module sod_decoder (
  // Clock and reset
  input  wire        core_clk,
  input  wire        sys_rst,
  // Operator byte from fetch
  input  wire        op_valid,
  input  wire [7:0]  op_byte,
  output wire        op_ready,
  // Edit mode request from the sequencer
  input  wire        edit_enter,
  // Decoded operation to the sequencer
  output reg         dec_valid_q,
  output reg  [4:0]  dec_class_q,
  output reg  [3:0]  dec_sub_q,
  output reg  [5:0]  dec_operand_q,
  output reg         dec_variant_q,
  output reg  [15:0] dec_code_q,
  // Mode state
  output reg  [1:0]  mode_q,
  output reg         vec_multi_q,
  output reg         prefix_pending_q
);

  // Decoder is always ready; the sequencer paces the fetch
  assign op_ready = 1'b1;

  // Variant decode of the second byte
  wire [4:0] var_class;
  wire [3:0] var_sub;

  sod_variant_decode u_var (
    .var_byte  (op_byte),
    .var_class (var_class),
    .var_sub   (var_sub)
  );

  // Primary decode
  function [8:0] prim_dec;
    input [7:0] b;
    begin
      prim_dec = {`SOD_CLS_INVALID, 4'h0};
      if (b[7:6] == 2'h0) begin
        prim_dec = {`SOD_CLS_VALUE_FETCH, 4'h0};
      end else if (b[7:6] == 2'h1) begin
        prim_dec = {`SOD_CLS_REF_FETCH, 4'h0};
      end else if (b[7:3] == 5'h10) begin
        prim_dec = {`SOD_CLS_ARITH, 1'b0, b[2:0]};
      end else if (b >= 8'h88 && b <= 8'h8d) begin
        prim_dec = {`SOD_CLS_RELATION, 1'b0, b[2:0]};
      end else if (b == 8'h8e) begin
        prim_dec = {`SOD_CLS_SIGN_INVERT, 4'h0};
      end else if (b == 8'h8f) begin
        prim_dec = {`SOD_CLS_EXT_MULTIPLY, 4'h0};
      end else if (b >= 8'h90 && b <= 8'h94) begin
        prim_dec = {`SOD_CLS_BITWISE, 1'b0, b[2:0]};
      end else if (b >= 8'h96 && b <= 8'h9f) begin
        prim_dec = {`SOD_CLS_BIT_FIELD, b[3:0]};
      end else if ((b[7:2] == 6'h28 || b[7:2] == 6'h2a) && b[1:0] != 2'h3) begin
        prim_dec = {`SOD_CLS_BRANCH, b[3:0]};
      end else if (b == 8'hb0 || b == 8'hb1 || b == 8'hb2 || b == 8'hb3 || b == 8'hbe) begin
        prim_dec = {`SOD_CLS_LITERAL, b[3:0]};
      end else if (b == `SOD_VECTOR_ENTER_SINGLE) begin
        prim_dec = {`SOD_CLS_VEC_ENTER, 4'h0};
      end else if (b == `SOD_VECTOR_ENTER_MULTIPLE) begin
        prim_dec = {`SOD_CLS_VEC_ENTER, 4'h1};
      end else if (b[7:4] == 4'hf && b[2:0] <= 3'h5) begin
        prim_dec = {`SOD_CLS_CHAR_COMPARE, b[3:0]};
      end
    end
  endfunction

  // Mode-independent codes
  function [4:0] common_dec;
    input [7:0] b;
    begin
      if (b == `SOD_NO_OPERATION)
        common_dec = `SOD_CLS_NOP;
      else if (b == `SOD_COND_HALT)
        common_dec = `SOD_CLS_HALT;
      else
        common_dec = `SOD_CLS_INVALID;
    end
  endfunction

  reg [1:0]  mode_d;
  reg        vec_multi_d;
  reg        prefix_pending_d;
  reg [4:0]  cls;
  reg [3:0]  sub;
  reg [8:0]  pd;
  reg        emit;

  always @* begin
    mode_d           = mode_q;
    vec_multi_d      = vec_multi_q;
    prefix_pending_d = prefix_pending_q;
    cls              = `SOD_CLS_INVALID;
    sub              = 4'h0;
    pd               = prim_dec(op_byte);
    emit             = 1'b0;
    if (op_valid) begin
      emit = 1'b1;
      if (prefix_pending_q) begin
        prefix_pending_d = 1'b0;
        cls = var_class;
        sub = var_sub;
      end else begin
        case (mode_q)
          `SOD_MODE_PRIMARY: begin
            if (op_byte == `SOD_ESCAPE_PREFIX) begin
              prefix_pending_d = 1'b1;
              emit = 1'b0;
            end else if (op_byte == `SOD_NO_OPERATION || op_byte == `SOD_COND_HALT
                         || op_byte == `SOD_INVALID_OPERATOR) begin
              cls = common_dec(op_byte);
            end else begin
              cls = pd[8:4];
              sub = pd[3:0];
              if (cls == `SOD_CLS_VEC_ENTER) begin
                mode_d      = `SOD_MODE_VECTOR;
                vec_multi_d = pd[0];
              end
            end
          end
          `SOD_MODE_EDIT: begin
            if (op_byte >= 8'hd0 && op_byte <= `SOD_EDIT_END) begin
              cls = `SOD_CLS_EDIT_MICRO;
              sub = op_byte[3:0];
              if (op_byte == `SOD_EDIT_END)
                mode_d = `SOD_MODE_PRIMARY;
            end else begin
              cls = common_dec(op_byte);
            end
          end
          `SOD_MODE_VECTOR: begin
            if (op_byte >= 8'he0 && op_byte <= 8'he5) begin
              cls = `SOD_CLS_VEC_LOAD;
              sub = op_byte[3:0];
            end else if (op_byte >= 8'hf0 && op_byte <= 8'hf5) begin
              cls = `SOD_CLS_VEC_STORE;
              sub = op_byte[3:0];
            end else if (op_byte == `SOD_VECTOR_EXIT) begin
              cls         = `SOD_CLS_VEC_EXIT;
              mode_d      = `SOD_MODE_PRIMARY;
              vec_multi_d = 1'b0;
            end else begin
              cls = common_dec(op_byte);
            end
          end
          default: begin
            mode_d = `SOD_MODE_PRIMARY;
          end
        endcase
      end
    end
  end

  // Edit mode entry from the sequencer's table-enter operations
  // is outside this block; edit_enter drives it.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      mode_q           <= `SOD_MODE_PRIMARY;
      vec_multi_q      <= 1'b0;
      prefix_pending_q <= 1'b0;
      dec_valid_q      <= 1'b0;
      dec_class_q      <= `SOD_CLS_INVALID;
      dec_sub_q        <= 4'h0;
      dec_operand_q    <= 6'h00;
      dec_variant_q    <= 1'b0;
      dec_code_q       <= 16'h0000;
    end else begin
      mode_q           <= (edit_enter && mode_d == `SOD_MODE_PRIMARY) ? `SOD_MODE_EDIT : mode_d;
      vec_multi_q      <= vec_multi_d;
      prefix_pending_q <= prefix_pending_d;
      dec_valid_q      <= emit;
      if (emit) begin
        dec_class_q   <= cls;
        dec_sub_q     <= sub;
        dec_operand_q <= op_byte[5:0];
        dec_variant_q <= prefix_pending_q;
        dec_code_q    <= prefix_pending_q ? {`SOD_ESCAPE_PREFIX, op_byte} : {8'h00, op_byte};
      end
    end
  end

endmodule // sod_decoder
`default_nettype wire

// ### sod_consts.vh
// Purpose: Constants for the stack operator decoder
// Assumes: Included by bare name
// Notes: Codes are operator byte values and operation class numbers
`ifndef SOD_CONSTS_VH
`define SOD_CONSTS_VH

// Decoding modes
`define SOD_MODE_PRIMARY 2'h0
`define SOD_MODE_EDIT    2'h1
`define SOD_MODE_VECTOR  2'h2

// Special operator bytes
`define SOD_ESCAPE_PREFIX          8'h95
`define SOD_NO_OPERATION           8'hfe
`define SOD_INVALID_OPERATOR       8'hff
`define SOD_COND_HALT              8'hdf
`define SOD_VECTOR_ENTER_SINGLE    8'he7
`define SOD_VECTOR_ENTER_MULTIPLE  8'hef
`define SOD_VECTOR_EXIT            8'he6
`define SOD_EDIT_END               8'hde

// Variant second bytes
`define SOD_VAR_IDLE         8'h44
`define SOD_VAR_IRQ_ENABLE   8'h46
`define SOD_VAR_IRQ_DISABLE  8'h47

// Operation classes
`define SOD_CLS_INVALID      5'h00
`define SOD_CLS_NOP          5'h01
`define SOD_CLS_VALUE_FETCH  5'h02
`define SOD_CLS_REF_FETCH    5'h03
`define SOD_CLS_ARITH        5'h04
`define SOD_CLS_RELATION     5'h05
`define SOD_CLS_SIGN_INVERT  5'h06
`define SOD_CLS_EXT_MULTIPLY 5'h07
`define SOD_CLS_BITWISE      5'h08
`define SOD_CLS_BIT_FIELD    5'h09
`define SOD_CLS_BRANCH       5'h0a
`define SOD_CLS_LITERAL      5'h0b
`define SOD_CLS_HALT         5'h0c
`define SOD_CLS_EDIT_MICRO   5'h0d
`define SOD_CLS_VEC_ENTER    5'h0e
`define SOD_CLS_VEC_EXIT     5'h0f
`define SOD_CLS_VEC_LOAD     5'h10
`define SOD_CLS_VEC_STORE    5'h11
`define SOD_CLS_CHAR_COMPARE 5'h12
`define SOD_CLS_IDLE         5'h13
`define SOD_CLS_IRQ_CONTROL  5'h14
`define SOD_CLS_SCAN_REL     5'h15
`define SOD_CLS_STRING_XFER  5'h16

`endif

// ### sod_variant_decode.v
// Purpose: Decode of the second byte of a variant operator
// Assumes: Prefix already seen by the caller
// Notes: Purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "sod_consts.vh"

module sod_variant_decode (
  // Second byte
  input  wire [7:0] var_byte,
  // Result
  output reg  [4:0] var_class,
  output reg  [3:0] var_sub
);

  always @* begin
    var_class = `SOD_CLS_INVALID;
    var_sub   = 4'h0;
    if (var_byte == `SOD_VAR_IDLE) begin
      var_class = `SOD_CLS_IDLE;
    end else if (var_byte == `SOD_VAR_IRQ_ENABLE || var_byte == `SOD_VAR_IRQ_DISABLE) begin
      var_class = `SOD_CLS_IRQ_CONTROL;
      var_sub   = {3'h0, var_byte[0]};
    end else if (var_byte[7:4] == 4'hf && var_byte[2:0] <= 3'h5) begin
      var_class = `SOD_CLS_SCAN_REL;
      var_sub   = var_byte[3:0];
    end else if (var_byte[7:4] == 4'hd && var_byte[2:0] <= 3'h5) begin
      var_class = `SOD_CLS_STRING_XFER;
      var_sub   = var_byte[3:0];
    end else if (var_byte == `SOD_COND_HALT) begin
      var_class = `SOD_CLS_HALT;
    end else if (var_byte == `SOD_NO_OPERATION) begin
      var_class = `SOD_CLS_NOP;
    end
  end

endmodule // sod_variant_decode
`default_nettype wire

// ### sod_decoder_chk.sv
// Purpose: Port checker for the operator decoder
// Assumes: Bound to every decoder instance
// Notes: Decoded outputs appear one cycle after the byte is taken
`timescale 1ns/1ps
`default_nettype none
`include "sod_consts.vh"

module sod_decoder_chk (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        sys_rst,
  // Operator byte
  input wire logic        op_valid,
  input wire logic [7:0]  op_byte,
  // Decoded result and state
  input wire logic        dec_valid_q,
  input wire logic [4:0]  dec_class_q,
  input wire logic [3:0]  dec_sub_q,
  input wire logic [5:0]  dec_operand_q,
  input wire logic        dec_variant_q,
  input wire logic [15:0] dec_code_q,
  input wire logic [1:0]  mode_q,
  input wire logic        vec_multi_q,
  input wire logic        prefix_pending_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire fresh = op_valid && !prefix_pending_q;
  wire prim  = fresh && mode_q == `SOD_MODE_PRIMARY;

  a_prefix_wait: assert property (
    prim && op_byte == 8'h95 |=> prefix_pending_q && !dec_valid_q)
    else $error("prefix byte not held");
  a_variant_join: assert property (
    prefix_pending_q && op_valid |=> dec_valid_q && dec_variant_q
    && dec_code_q == {8'h95, $past(op_byte)}) else $error("variant code wrong");
  a_value_fetch: assert property (
    prim && op_byte < 8'h40 |=> dec_class_q == `SOD_CLS_VALUE_FETCH
    && dec_operand_q == $past(op_byte[5:0])) else $error("value fetch wrong");
  a_ref_fetch: assert property (
    prim && op_byte[7:6] == 2'b01 |=> dec_valid_q
    && dec_class_q == `SOD_CLS_REF_FETCH) else $error("reference fetch wrong");
  a_nop_any: assert property (
    fresh && op_byte == 8'hfe |=> dec_class_q == `SOD_CLS_NOP)
    else $error("no operation wrong");
  a_invalid_any: assert property (
    fresh && op_byte == 8'hff |=> dec_class_q == `SOD_CLS_INVALID)
    else $error("invalid operator wrong");
  a_halt_any: assert property (
    fresh && op_byte == 8'hdf |=> dec_class_q == `SOD_CLS_HALT)
    else $error("halt wrong");
  a_edit_micro: assert property (
    fresh && mode_q == `SOD_MODE_EDIT && op_byte >= 8'hd0 && op_byte <= 8'hde
    |=> dec_class_q == `SOD_CLS_EDIT_MICRO && dec_sub_q == $past(op_byte[3:0]))
    else $error("edit micro wrong");
  a_edit_end: assert property (
    fresh && mode_q == `SOD_MODE_EDIT && op_byte == 8'hde |=> mode_q == `SOD_MODE_PRIMARY)
    else $error("edit end wrong");
  a_vec_enter: assert property (
    prim && (op_byte == 8'he7 || op_byte == 8'hef) |=>
    mode_q == `SOD_MODE_VECTOR && vec_multi_q == $past(op_byte[3])) else $error("vector enter");
  a_vec_exit: assert property (
    fresh && mode_q == `SOD_MODE_VECTOR && op_byte == 8'he6 |=>
    mode_q == `SOD_MODE_PRIMARY && dec_class_q == `SOD_CLS_VEC_EXIT) else $error("vector exit");
  a_vec_load: assert property (
    fresh && mode_q == `SOD_MODE_VECTOR && op_byte >= 8'he0 && op_byte <= 8'he5
    |=> dec_class_q == `SOD_CLS_VEC_LOAD) else $error("vector load wrong");
  a_vec_store: assert property (
    fresh && mode_q == `SOD_MODE_VECTOR && op_byte >= 8'hf0 && op_byte <= 8'hf5
    |=> dec_class_q == `SOD_CLS_VEC_STORE) else $error("vector store wrong");
  a_arith_order: assert property (
    prim && op_byte[7:3] == 5'h10 |=> dec_class_q == `SOD_CLS_ARITH
    && dec_sub_q == $past(op_byte[3:0])) else $error("arith select wrong");
endmodule // sod_decoder_chk

bind sod_decoder sod_decoder_chk u_chk (.core_clk, .sys_rst, .op_valid, .op_byte, .dec_valid_q,
  .dec_class_q, .dec_sub_q, .dec_operand_q, .dec_variant_q, .dec_code_q, .mode_q, .vec_multi_q,
  .prefix_pending_q);
`default_nettype wire

// ### sod_fetch_model.sv
// Purpose: Code fetch model offering operator bytes
// Assumes: Bytes change at the falling edge
// Notes: Released byte lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none

module sod_fetch_model (
  // Clock
  input  wire logic       core_clk,
  // Operator byte
  output var  logic       op_valid,
  output var  logic [7:0] op_byte
);
  initial begin
    op_valid = 1'b0;
    op_byte = 8'h00;
  end
  task automatic put(input logic [7:0] b);
    @(negedge core_clk);
    op_valid = 1'b1;
    op_byte = b;
  endtask
  task automatic idle();
    @(negedge core_clk);
    op_valid = 1'b0;
    op_byte = ~op_byte;
  endtask
endmodule // sod_fetch_model
`default_nettype wire

// ### sod_decoder_tb.sv
// Purpose: Self-checking bench for the operator decoder
// Assumes: Edit mode entered by pulsing edit_enter while idle
// Notes: Primary sweep of all bytes but 95, E7 and EF, vector and variant tables, random burst
`timescale 1ns/1ps
`default_nettype none
`include "sod_consts.vh"

module sod_decoder_tb;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  b;
  logic [7:0]  prev;
  logic        edit_enter = 1'b0;
  integer      seed = 61;
  int          n_fail = 0, tests_run = 0, i;
  wire         op_valid, op_ready, dec_valid_q, dec_variant_q, vec_multi_q, prefix_pending_q;
  wire  [7:0]  op_byte;
  wire  [4:0]  dec_class_q;
  wire  [3:0]  dec_sub_q;
  wire  [5:0]  dec_operand_q;
  wire  [15:0] dec_code_q;
  wire  [1:0]  mode_q;

  always #50 core_clk = ~core_clk;
  sod_fetch_model u_fetch (.core_clk, .op_valid, .op_byte);
  sod_decoder u_dut (.core_clk, .sys_rst, .op_valid, .op_byte, .op_ready, .edit_enter,
    .dec_valid_q, .dec_class_q, .dec_sub_q, .dec_operand_q, .dec_variant_q, .dec_code_q,
    .mode_q, .vec_multi_q, .prefix_pending_q);

  task summarize;
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [4:0] pcls(input logic [7:0] c);
    if (c < 8'h40) return `SOD_CLS_VALUE_FETCH;
    if (c < 8'h80) return `SOD_CLS_REF_FETCH;
    if (c < 8'h88) return `SOD_CLS_ARITH;
    if (c < 8'h8e) return `SOD_CLS_RELATION;
    if (c == 8'h8e) return `SOD_CLS_SIGN_INVERT;
    if (c == 8'h8f) return `SOD_CLS_EXT_MULTIPLY;
    if (c < 8'h95) return `SOD_CLS_BITWISE;
    if (c[7:4] == 4'h9 && c > 8'h95) return `SOD_CLS_BIT_FIELD;
    if (c inside {[8'ha0:8'ha2], [8'ha8:8'haa]}) return `SOD_CLS_BRANCH;
    if (c inside {[8'hb0:8'hb3], 8'hbe}) return `SOD_CLS_LITERAL;
    if (c == 8'hdf) return `SOD_CLS_HALT;
    if (c[7:4] == 4'hf && c[2:1] != 2'b11) return `SOD_CLS_CHAR_COMPARE;
    if (c == 8'hfe) return `SOD_CLS_NOP;
    return `SOD_CLS_INVALID;
  endfunction
  function automatic bit cov(input logic [7:0] c);
    return c != 8'h95 && c != 8'he7 && c != 8'hef;
  endfunction
  task op(input logic [7:0] c, input logic [4:0] cls);
    u_fetch.put(c);
    u_fetch.idle();
    chk("valid", dec_valid_q, 1'b1);
    chk("ready", op_ready, 1'b1);
    chk("class", dec_class_q, cls);
  endtask
  task vop(input logic [7:0] c, input logic [4:0] cls);
    u_fetch.put(8'h95);
    op(c, cls);
    chk("variant", dec_variant_q, 1'b1);
    chk("code", dec_code_q, {8'h95, c});
  endtask
  task rst();
    @(negedge core_clk);
    sys_rst = 1'b1;
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
  endtask

  initial begin
    #2000000;
    n_fail++;
    summarize;
  end
  initial begin
    repeat (20) @(negedge core_clk);
    sys_rst = 1'b0;
    chk("mode", mode_q, 2'h0);
    for (i = 0; i < 256; i++) begin
      if (cov(i[7:0])) begin
        op(i[7:0], pcls(i[7:0]));
        chk("code", dec_code_q, {8'h00, i[7:0]});
        if (i < 128) chk("operand", dec_operand_q, i[5:0]);
        if (i[7:3] == 5'h10) chk("sub", dec_sub_q, i[3:0]);
      end
    end
    op(8'he7, `SOD_CLS_VEC_ENTER);
    chk("multi", vec_multi_q, 1'b0);
    for (i = 0; i < 6; i++) begin
      op({5'h1c, i[2:0]}, `SOD_CLS_VEC_LOAD);
      op({5'h1e, i[2:0]}, `SOD_CLS_VEC_STORE);
    end
    op(8'hfe, `SOD_CLS_NOP);
    op(8'hff, `SOD_CLS_INVALID);
    op(8'hdf, `SOD_CLS_HALT);
    op(8'he8, `SOD_CLS_INVALID);
    op(8'he6, `SOD_CLS_VEC_EXIT);
    chk("mode", mode_q, 2'h0);
    op(8'hef, `SOD_CLS_VEC_ENTER);
    chk("multi", vec_multi_q, 1'b1);
    op(8'he6, `SOD_CLS_VEC_EXIT);
    @(negedge core_clk);
    edit_enter = 1'b1;
    @(negedge core_clk);
    edit_enter = 1'b0;
    chk("mode", mode_q, 2'h1);
    op(8'hfe, `SOD_CLS_NOP);
    op(8'hff, `SOD_CLS_INVALID);
    op(8'hdf, `SOD_CLS_HALT);
    op(8'h80, `SOD_CLS_INVALID);
    for (i = 0; i < 15; i++) begin
      op({4'hd, i[3:0]}, `SOD_CLS_EDIT_MICRO);
      chk("sub", dec_sub_q, i[3:0]);
      chk("mode", mode_q, (i < 14) ? 2'h1 : 2'h0);
    end
    for (i = 0; i < 6; i++) begin
      vop({5'h1e, i[2:0]}, `SOD_CLS_SCAN_REL);
      vop({5'h1f, i[2:0]}, `SOD_CLS_SCAN_REL);
      vop({5'h1a, i[2:0]}, `SOD_CLS_STRING_XFER);
      vop({5'h1b, i[2:0]}, `SOD_CLS_STRING_XFER);
    end
    vop(8'h44, `SOD_CLS_IDLE);
    vop(8'h46, `SOD_CLS_IRQ_CONTROL);
    chk("sub", dec_sub_q, 4'h0);
    vop(8'h47, `SOD_CLS_IRQ_CONTROL);
    chk("sub", dec_sub_q, 4'h1);
    vop(8'hdf, `SOD_CLS_HALT);
    vop(8'hd6, `SOD_CLS_INVALID);
    for (i = 0; i < 300; i++) begin
      b = 8'($random(seed));
      if (!cov(b)) b = 8'h80;
      u_fetch.put(b);
      if (i > 0) chk("class", dec_class_q, pcls(prev));
      prev = b;
    end
    u_fetch.idle();
    chk("class", dec_class_q, pcls(b));
    u_fetch.put(8'h95);
    u_fetch.idle();
    chk("pending", prefix_pending_q, 1'b1);
    rst();
    chk("pending", prefix_pending_q, 1'b0);
    op(8'he7, `SOD_CLS_VEC_ENTER);
    rst();
    chk("mode", mode_q, 2'h0);
    op(8'h80, `SOD_CLS_ARITH);
    chk("variant", dec_variant_q, 1'b0);
    summarize;
  end
endmodule // sod_decoder_tb
`default_nettype wire
